// File: dca_pkg.sv
// =====================================================================
// shared constants of the diskette adapter control port
// =====================================================================
package dca_pkg;

    // =================================================================
    // i/o addresses decoded on the bus (10-bit i/o space)
    // =================================================================
    localparam int ADDR_W = 10;
    localparam logic [9:0] ADDR_DRIVE_CONTROL_LATCH = 10'h3f2;
    localparam logic [9:0] ADDR_DISK_CTRL_MAIN_STATUS = 10'h3f4;
    localparam logic [9:0] ADDR_DISK_CTRL_DATA_PORT = 10'h3f5;

    // =================================================================
    // drive control latch layout
    // =================================================================
    localparam int DATA_W = 8;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam int LATCH_SEL_LSB = 0;
    localparam int LATCH_SEL_MSB = 1;
    localparam int LATCH_CORE_RUN = 2;
    localparam int LATCH_REQ_ENABLE = 3;
    localparam int LATCH_MOTOR_A = 4;
    localparam int LATCH_MOTOR_B = 5;

    // =================================================================
    // drive codes in latch bits 1:0
    // =================================================================
    localparam logic [1:0] DRIVE_A_CODE = 2'h0;
    localparam logic [1:0] DRIVE_B_CODE = 2'h1;

    // =================================================================
    // controller core register select (a0 line)
    // =================================================================
    localparam logic CORE_SEL_STATUS = 1'h0;
    localparam logic CORE_SEL_DATA = 1'h1;

    // number of commands the core understands
    localparam int CORE_COMMAND_COUNT = 15;

endpackage : dca_pkg

// File: dca_drv_if.sv
`timescale 1ns/10ps
// =====================================================================
// per-drive link between latch logic and select gate
// =====================================================================
interface dca_drv_if;
    logic [1:0] sel_code; // drive code from latch bits 1:0
    logic motor_on;       // motor bit of this drive
    logic select;         // gated select back to the top

    // latch side drives code and motor, reads select
    modport ctl (output sel_code, output motor_on, input select);
    // gate side turns code and motor into a select
    modport gate (input sel_code, input motor_on, output select);
endinterface : dca_drv_if

// File: dca_drive_gate.sv
`timescale 1ns/10ps
// =====================================================================
// select gate for one drive, one instance per drive
// =====================================================================
module dca_drive_gate #(
    parameter logic [1:0] DRIVE_CODE = dca_pkg::DRIVE_A_CODE
) (
    dca_drv_if.gate drv
);
    // a drive is picked only if its code matches and its motor runs;
    // this keeps a stopped drive from ever seeing a select line
    assign drv.select = drv.motor_on && (drv.sel_code == DRIVE_CODE);
endmodule : dca_drive_gate

// File: dca_port.sv
`timescale 1ns/10ps
// Behaviour
// RQ1 - write-only 8-bit drive control latch at 3f2
// RQ2 - i/o reset clears every latch bit
// RQ3 - bits 1:0 pick drive, only with motor on
// RQ4 - latch bit 2 low holds core in reset
// RQ5 - bit 3 gates core interrupt and dma requests
// RQ6 - bits 4 and 5 drive motors a and b
// RQ7 - core main status readable at 3f4 anytime
// RQ8 - core data port stack mapped at 3f5
// RQ9 - commands run command, execution, result phases
// RQ10 - core executes fifteen multi-byte commands
// RQ11 - latch loads on write strobe, never read
module dca_port (
    input wire logic ref_clk,
    input wire logic rst,
    // i/o bus side, same clock as ref_clk
    input wire logic [9:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    output logic io_irq,
    output logic io_irq_oe,
    output logic io_drq,
    output logic io_drq_oe,
    // controller core side
    input wire logic core_int,
    input wire logic core_drq,
    input wire logic [7:0] core_rdata,
    output logic core_reset,
    output logic core_rd,
    output logic core_wr,
    output logic core_a0,
    output logic [7:0] core_wdata,
    // diskette drive cable side
    output logic motor_a,
    output logic motor_b,
    output logic drive_a_sel,
    output logic drive_b_sel
);
    // =================================================================
    // state
    // =================================================================
    logic [7:0] latch_r;      // drive control latch
    logic [7:0] io_rdata_r;   // read data toward the bus
    logic io_rdata_oe_r;      // bus data driver enable
    logic io_irq_r;           // gated interrupt request
    logic io_irq_oe_r;        // interrupt driver enable
    logic io_drq_r;           // gated dma request
    logic io_drq_oe_r;        // dma driver enable
    logic core_reset_r;       // reset into the core
    logic core_rd_r;          // read strobe into the core
    logic core_wr_r;          // write strobe into the core
    logic core_a0_r;          // status or data select
    logic [7:0] core_wdata_r; // write data into the core
    logic motor_a_r;          // motor enable drive a
    logic motor_b_r;          // motor enable drive b
    logic drive_a_sel_r;      // select drive a
    logic drive_b_sel_r;      // select drive b

    // address hits
    logic hit_latch;
    logic hit_status;
    logic hit_data;
    logic hit_core;

    assign hit_latch = (io_addr == dca_pkg::ADDR_DRIVE_CONTROL_LATCH);
    assign hit_status = (io_addr == dca_pkg::ADDR_DISK_CTRL_MAIN_STATUS);
    assign hit_data = (io_addr == dca_pkg::ADDR_DISK_CTRL_DATA_PORT);
    assign hit_core = hit_status || hit_data;

    // =================================================================
    // drive control latch
    // =================================================================
    // RQ1 RQ11 latch write
    // the latch has no read path: software must keep its own copy
    always_ff @(posedge ref_clk)
    begin
        // RQ2 reset clears latch
        if (rst)
        begin
            latch_r <= dca_pkg::LATCH_RESET;
        end
        else if (io_wr && hit_latch)
        begin
            latch_r <= io_wdata;
        end
    end

    // =================================================================
    // per-drive select gates
    // =================================================================
    dca_drv_if drv_a ();
    dca_drv_if drv_b ();

    // RQ3 drive code decode
    assign drv_a.sel_code =
        latch_r[dca_pkg::LATCH_SEL_MSB:dca_pkg::LATCH_SEL_LSB];
    assign drv_b.sel_code =
        latch_r[dca_pkg::LATCH_SEL_MSB:dca_pkg::LATCH_SEL_LSB];
    assign drv_a.motor_on = latch_r[dca_pkg::LATCH_MOTOR_A];
    assign drv_b.motor_on = latch_r[dca_pkg::LATCH_MOTOR_B];

    dca_drive_gate #(.DRIVE_CODE(dca_pkg::DRIVE_A_CODE)) u_gate_a (
        .drv(drv_a)
    );
    dca_drive_gate #(.DRIVE_CODE(dca_pkg::DRIVE_B_CODE)) u_gate_b (
        .drv(drv_b)
    );

    // =================================================================
    // drive cable outputs
    // =================================================================
    // RQ6 motor enables and select blocking
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            motor_a_r <= 1'b0;
            motor_b_r <= 1'b0;
            drive_a_sel_r <= 1'b0;
            drive_b_sel_r <= 1'b0;
        end
        else
        begin
            motor_a_r <= latch_r[dca_pkg::LATCH_MOTOR_A];
            motor_b_r <= latch_r[dca_pkg::LATCH_MOTOR_B];
            drive_a_sel_r <= drv_a.select;
            drive_b_sel_r <= drv_b.select;
        end
    end

    // =================================================================
    // core reset and request gating
    // =================================================================
    // RQ4 core held in reset
    // reset is also asserted during bus reset by rst itself, and stays on after it since the latch clears
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            core_reset_r <= 1'b1;
        end
        else
        begin
            core_reset_r <= !latch_r[dca_pkg::LATCH_CORE_RUN];
        end
    end

    // RQ5 gate requests onto bus
    // drivers release the lines so another adapter may share the level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            io_irq_r <= 1'b0;
            io_drq_r <= 1'b0;
            io_irq_oe_r <= 1'b0;
            io_drq_oe_r <= 1'b0;
        end
        else
        begin
            io_irq_oe_r <= latch_r[dca_pkg::LATCH_REQ_ENABLE];
            io_drq_oe_r <= latch_r[dca_pkg::LATCH_REQ_ENABLE];
            io_irq_r <= core_int && latch_r[dca_pkg::LATCH_REQ_ENABLE];
            io_drq_r <= core_drq && latch_r[dca_pkg::LATCH_REQ_ENABLE];
        end
    end

    // =================================================================
    // controller core register access
    // =================================================================
    // RQ8 data port pass-through
    // the core sequences its three phases and its fifteen commands
    // (RQ9 RQ10); this port only moves bytes, one per strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            core_rd_r <= 1'b0;
            core_wr_r <= 1'b0;
            core_a0_r <= dca_pkg::CORE_SEL_STATUS;
            core_wdata_r <= 8'h00;
        end
        else
        begin
            // RQ7 status read-only
            core_rd_r <= io_rd && hit_core;
            core_wr_r <= io_wr && hit_data;
            if (hit_core)
            begin
                core_a0_r <= hit_data ? dca_pkg::CORE_SEL_DATA
                                      : dca_pkg::CORE_SEL_STATUS;
            end
            if (io_wr && hit_data)
            begin
                core_wdata_r <= io_wdata;
            end
        end
    end

    // RQ11 no bus drive for latch
    // read data is captured from the core one cycle after its strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            io_rdata_r <= 8'h00;
            io_rdata_oe_r <= 1'b0;
        end
        else
        begin
            io_rdata_oe_r <= core_rd_r;
            if (core_rd_r)
            begin
                io_rdata_r <= core_rdata;
            end
        end
    end

    // =================================================================
    // outputs
    // =================================================================
    assign io_rdata = io_rdata_r;
    assign io_rdata_oe = io_rdata_oe_r;
    assign io_irq = io_irq_r;
    assign io_irq_oe = io_irq_oe_r;
    assign io_drq = io_drq_r;
    assign io_drq_oe = io_drq_oe_r;
    assign core_reset = core_reset_r;
    assign core_rd = core_rd_r;
    assign core_wr = core_wr_r;
    assign core_a0 = core_a0_r;
    assign core_wdata = core_wdata_r;
    assign motor_a = motor_a_r;
    assign motor_b = motor_b_r;
    assign drive_a_sel = drive_a_sel_r;
    assign drive_b_sel = drive_b_sel_r;

    // =================================================================
    // assertions
    // =================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_status_rd;
        io_rd && hit_status;
    endsequence
    sequence s_core_status_strobe;
        core_rd_r && (core_a0_r == dca_pkg::CORE_SEL_STATUS);
    endsequence

    chk_latch_load: assert property ( // RQ1
        io_wr && hit_latch |=> latch_r == $past(io_wdata))
        else $error("latch did not load written byte");
    chk_latch_reset: assert property ( // RQ2
        $fell(rst) |-> latch_r == dca_pkg::LATCH_RESET)
        else $error("latch not cleared by reset");
    chk_drive_select: assert property ( // RQ3
        ##1 (drive_a_sel_r == $past(latch_r[dca_pkg::LATCH_MOTOR_A] &&
        latch_r[dca_pkg::LATCH_SEL_MSB:dca_pkg::LATCH_SEL_LSB] ==
        dca_pkg::DRIVE_A_CODE) &&
        drive_b_sel_r == $past(latch_r[dca_pkg::LATCH_MOTOR_B] &&
        latch_r[dca_pkg::LATCH_SEL_MSB:dca_pkg::LATCH_SEL_LSB] ==
        dca_pkg::DRIVE_B_CODE)))
        else $error("drive select decode wrong");
    chk_core_reset: assert property ( // RQ4
        ##1 core_reset_r == !$past(latch_r[dca_pkg::LATCH_CORE_RUN]))
        else $error("core not held in reset");
    chk_req_gate: assert property ( // RQ5
        ##1 (io_irq_oe_r == $past(latch_r[dca_pkg::LATCH_REQ_ENABLE]) &&
        io_drq_oe_r == $past(latch_r[dca_pkg::LATCH_REQ_ENABLE]) &&
        io_irq_r == $past(core_int && latch_r[dca_pkg::LATCH_REQ_ENABLE]) &&
        io_drq_r == $past(core_drq && latch_r[dca_pkg::LATCH_REQ_ENABLE])))
        else $error("request gating onto bus wrong");
    chk_motor_block: assert property ( // RQ6
        ##1 (motor_a_r == $past(latch_r[dca_pkg::LATCH_MOTOR_A]) &&
        motor_b_r == $past(latch_r[dca_pkg::LATCH_MOTOR_B]) &&
        (motor_a_r || !drive_a_sel_r) && (motor_b_r || !drive_b_sel_r)))
        else $error("motor enable or select blocking wrong");
    chk_status_read: assert property ( // RQ7
        s_status_rd |=> s_core_status_strobe ##1
        (io_rdata_oe_r && io_rdata_r == $past(core_rdata)))
        else $error("status read path broken");
    chk_data_write: assert property ( // RQ8
        io_wr && hit_data |=> core_wr_r && core_a0_r
        && core_wdata_r == $past(io_wdata))
        else $error("data port write not passed to core");
    chk_latch_noread: assert property ( // RQ11
        io_rd && hit_latch |=> ##1 !io_rdata_oe_r)
        else $error("bus driven on latch read");

endmodule : dca_port

// File: dca_core_model.sv
`timescale 1ns/10ps
// =====================================================================
// behavioural disk controller core: echoes command bytes as results
// =====================================================================
module dca_core_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic core_reset,
    input wire logic core_rd,
    input wire logic core_wr,
    input wire logic core_a0,
    input wire logic [7:0] core_wdata,
    input wire logic int_req,
    input wire logic drq_req,
    output logic [7:0] core_rdata,
    output logic core_int,
    output logic core_drq
);
    logic [7:0] fifo_r [16]; // parameter bytes, later result bytes
    logic [3:0] wr_ptr_r; // next slot written
    logic [3:0] rd_ptr_r; // next slot read back
    logic [7:0] status; // main status byte

    assign status = (wr_ptr_r == rd_ptr_r) ? 8'h80 : 8'hd0;
    // status or data register on the bus, picked by core_a0
    // idle bus shows the inverse so a stale value never matches
    assign core_rdata = core_rd ? (core_a0 ? fifo_r[rd_ptr_r] : status)
                                : ~status;
    assign core_int = int_req & ~core_reset;
    assign core_drq = drq_req & ~core_reset;

    // =================================================================
    // command stack
    // =================================================================
    // multi-byte phases
    always_ff @(posedge ref_clk)
    begin
        if (rst || core_reset)
        begin
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
        end
        else
        begin
            // command phase: store a byte
            if (core_wr && core_a0)
            begin
                fifo_r[wr_ptr_r] <= core_wdata;
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            // result phase: pop a byte, none left means done
            if (core_rd && core_a0 && (wr_ptr_r != rd_ptr_r))
            begin
                rd_ptr_r <= rd_ptr_r + 4'h1;
            end
        end
    end
endmodule : dca_core_model

// File: dca_port_tb.sv
`timescale 1ns/10ps
// =====================================================================
// self-checking bench of the diskette adapter control port
// =====================================================================
module dca_port_tb;
    logic ref_clk, rst, io_rd, io_wr, int_req, drq_req;
    logic [9:0] io_addr; // bus address
    logic [7:0] io_wdata, io_rdata, core_rdata, core_wdata, rd_v;
    logic io_rdata_oe, io_irq, io_irq_oe, io_drq, io_drq_oe;
    logic core_int, core_drq, core_reset, core_rd, core_wr, core_a0;
    logic motor_a, motor_b, drive_a_sel, drive_b_sel, got;
    int n_fail, cmp_count;
    logic [7:0] tbl [8] = '{8'h35, 8'h14, 8'h04, 8'h21,
                            8'h01, 8'h12, 8'h3b, 8'h1c};

    dca_port i_dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .io_irq(io_irq),
        .io_irq_oe(io_irq_oe), .io_drq(io_drq), .io_drq_oe(io_drq_oe),
        .core_int(core_int), .core_drq(core_drq), .core_rdata(core_rdata),
        .core_reset(core_reset), .core_rd(core_rd), .core_wr(core_wr),
        .core_a0(core_a0), .core_wdata(core_wdata), .motor_a(motor_a),
        .motor_b(motor_b), .drive_a_sel(drive_a_sel),
        .drive_b_sel(drive_b_sel));
    dca_core_model i_core (.ref_clk(ref_clk), .rst(rst),
        .core_reset(core_reset), .core_rd(core_rd), .core_wr(core_wr),
        .core_a0(core_a0), .core_wdata(core_wdata), .int_req(int_req),
        .drq_req(drq_req), .core_rdata(core_rdata), .core_int(core_int),
        .core_drq(core_drq));

    // =================================================================
    // clock and shared tasks
    // =================================================================
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // one-cycle write strobe
    task io_write(input logic [9:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        io_wr <= 1'b1;
        io_addr <= addr;
        io_wdata <= data;
        @(posedge ref_clk);
        io_wr <= 1'b0;
    endtask : io_write

    // one-cycle read strobe, bounded wait for the data enable
    task io_read(input logic [9:0] addr);
        @(posedge ref_clk);
        io_rd <= 1'b1;
        io_addr <= addr;
        @(posedge ref_clk);
        io_rd <= 1'b0;
        got = 1'b0;
        rd_v = 8'h00;
        repeat (4)
        begin
            @(posedge ref_clk);
            #1;
            if (io_rdata_oe === 1'b1 && !got)
            begin
                got = 1'b1;
                rd_v = io_rdata;
            end
        end
    endtask : io_read

    // a read that must be answered with exp
    task read_expect(input logic [9:0] addr, input logic [7:0] exp);
        io_read(addr);
        check({7'h0, got}, 8'h01);
        check(rd_v, exp);
    endtask : read_expect

    // latch write, then all levels worked out from the bits
    task latch_expect(input logic [7:0] v);
        io_write(dca_pkg::ADDR_DRIVE_CONTROL_LATCH, v);
        repeat (3) @(posedge ref_clk);
        #1;
        check({4'h0, motor_b, motor_a, drive_b_sel, drive_a_sel},
              {4'h0, v[5], v[4], v[1:0] == 2'h1 && v[5],
               v[1:0] == 2'h0 && v[4]});
        check({3'h0, core_reset, io_irq_oe, io_drq_oe, io_irq, io_drq},
              {3'h0, ~v[2], v[3], v[3], v[3] & v[2], v[3] & v[2]});
    endtask : latch_expect

    // =================================================================
    // main sequence
    // =================================================================
    initial
    begin
        {rst, io_rd, io_wr, int_req, drq_req} = 5'h10;
        io_addr = 10'h000;
        io_wdata = 8'h00;
        n_fail = 0;
        cmp_count = 0;
        repeat (16) @(posedge ref_clk);
        #1;
        check({motor_a, motor_b, drive_a_sel, drive_b_sel, io_irq_oe,
               io_drq_oe, io_rdata_oe, core_reset}, 8'h01);
        @(posedge ref_clk);
        rst <= 1'b0;
        int_req <= 1'b1;
        drq_req <= 1'b1;
        foreach (tbl[i])
            latch_expect(tbl[i]);
        // refused places: latch not readable, unmapped ignored
        io_read(dca_pkg::ADDR_DRIVE_CONTROL_LATCH);
        check({7'h0, got}, 8'h00);
        io_write(10'h3f3, 8'h00);
        io_read(10'h3f3);
        check({6'h0, got, motor_a}, 8'h01);
        // command, result, back to idle status
        read_expect(dca_pkg::ADDR_DISK_CTRL_MAIN_STATUS, 8'h80);
        io_write(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'h03);
        io_write(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'h5f);
        io_write(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'ha0);
        read_expect(dca_pkg::ADDR_DISK_CTRL_MAIN_STATUS, 8'hd0);
        read_expect(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'h03);
        read_expect(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'h5f);
        read_expect(dca_pkg::ADDR_DISK_CTRL_DATA_PORT, 8'ha0);
        read_expect(dca_pkg::ADDR_DISK_CTRL_MAIN_STATUS, 8'h80);
        // reset in mid-run clears the latch again
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        check({5'h0, motor_a, io_irq_oe, core_reset}, 8'h01);
        // second release: first edge shows idle levels, then work again
        @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check({5'h0, motor_a, io_irq_oe, core_reset}, 8'h01);
        latch_expect(8'h2d);
        // dma request dropped alone must not pull the interrupt down
        @(posedge ref_clk);
        drq_req <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({6'h0, io_irq, io_drq}, 8'h02);
        finish_test();
    end
endmodule : dca_port_tb
